// ---- inc/psc_pkg.sv ----
// constants and types for the polled spi command-port host controller
package psc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS        = 10;
	localparam int HALF_NS       = 50;
	localparam int HALF_CYC      = (HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_NS        = 100;
	localparam int GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEV_RST_NS    = 1000;
	localparam int DEV_RST_CYC   = (DEV_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int POLL_US       = 100;
	localparam int PSC_POLL_CYC  = POLL_US * 1000 / CLK_NS;
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [7:0] GAP_LAST  = 8'(GAP_CYC - 1);
	localparam logic [7:0] RST_LAST  = 8'(DEV_RST_CYC - 1);
	localparam logic [7:0] PH_ZERO   = 8'h00;
	// ------------------------------------------------------------
	// frame layout, counted in serial clock cycles
	// ------------------------------------------------------------
	localparam logic [3:0] BIT_START  = 4'h0;
	localparam logic [3:0] BIT_DIR    = 4'h1;
	localparam logic [3:0] BIT_TGT    = 4'h2;
	localparam logic [3:0] BIT_DFIRST = 4'h3;
	localparam logic [3:0] BIT_DLAST  = 4'hA;
	localparam logic [3:0] BIT_STAT   = 4'hB;
	localparam logic [3:0] BIT_LAST   = 4'hC;
	// ------------------------------------------------------------
	// status byte fields and trailing status bit
	// ------------------------------------------------------------
	localparam int RX_FULL_N_BIT  = 0;
	localparam int TX_EMPTY_N_BIT = 1;
	localparam int RX_IRQ_EN_BIT  = 4;
	localparam int TX_IRQ_EN_BIT  = 5;
	localparam logic STAT_NEW = 1'h0;
	localparam logic STAT_OLD = 1'h1;
	localparam logic STAT_ACCEPT = 1'h0;
	localparam logic STAT_REJECT = 1'h1;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSC_OP_WRITE  = 2'h0,
		PSC_OP_UNUSED = 2'h1,
		PSC_OP_READ   = 2'h2,
		PSC_OP_STATUS = 2'h3
	} psc_op_t;
	typedef enum logic [4:0] {
		ST_RST  = 5'h01,
		ST_IDLE = 5'h02,
		ST_LOW  = 5'h04,
		ST_HIGH = 5'h08,
		ST_GAP  = 5'h10
	} psc_state_t;
endpackage

// ---- logic/psc_host.sv ----
// host controller driving the polled spi command port of the device
`timescale 1ns/10ps
// Operation
// R1: straps select spi, sampled at reset
// R2: master makes serial clock and chip select
// R3: serial clock never above 12 MHz
// R4: one byte per thirteen-cycle transaction
// R5: start is data-in and select high
// R6: direction then target bit encode operation
// R7: data byte shifted msb first
// R8: all signals timed to rising clock edge
// R9: select stays high through whole transaction
// R10: select low one cycle after data ops
// R11: read status bit zero means new
// R12: old read data discarded, read repeated
// R13: trailing status valid until next rise
// R14: write byte then status bit follows
// R15: write status zero accepted, one rejected
// R16: rejected write byte is resent until accepted
// R17: poll reads periodically and before commands
// R18: status read returns byte plus zero bit
// R19: status byte holds flags and enables
// R20: early select drop abandons device transfer
module psc_host
	import psc_pkg::*;
#(
	parameter int unsigned POLL_CYC = PSC_POLL_CYC
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_op,
	input  wire logic [7:0] cmd_wdata,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_full_n,
	output logic            tx_empty_n,
	output logic            dev_reset_n,
	output logic            iface_strap_high,
	output logic            iface_strap_low,
	output logic            strap_oe_n,
	output logic            spi_sclk,
	output logic            spi_cs,
	output logic            spi_sdi,
	input  wire logic       spi_sdo
);
	function automatic logic psc_is_data(input psc_op_t k);
		return k != PSC_OP_STATUS;
	endfunction

	psc_state_t  st_q;
	logic [7:0]  ph_q;
	logic [3:0]  bit_q;
	psc_op_t     kind_q;
	psc_op_t     pend_op_q;
	logic        pend_q, rpt_q, again_q;
	logic [7:0]  wdata_q;
	logic [7:0]  sh_q;
	logic        stat_bit_q;
	logic [23:0] poll_q;
	logic        sdo_m_q, sdo_s_q;
	logic        ph_last, frame_end, poll_due;
	logic        take_w, start_w, again_w;
	logic        npend_w, done_w, newdata_w;
	psc_op_t     nkind_w;

	// ------------------------------------------------------------
	// input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdo_m_q <= 1'h0;
			sdo_s_q <= 1'h0;
		end else begin
			sdo_m_q <= spi_sdo;
			sdo_s_q <= sdo_m_q;
		end
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	always_comb begin
		if (st_q == ST_GAP)
			ph_last = (ph_q == GAP_LAST);
		else if (st_q == ST_RST)
			ph_last = (ph_q == RST_LAST);
		else
			ph_last = (ph_q == HALF_LAST);
		frame_end = (st_q == ST_HIGH) && ph_last && (bit_q == BIT_LAST); // [R4]
		poll_due  = (poll_q == 24'(POLL_CYC - 1));
		take_w    = (st_q == ST_IDLE) && cmd_valid && cmd_ready &&
			(psc_op_t'(cmd_op) != PSC_OP_UNUSED); // [R6]
		start_w   = (st_q == ST_IDLE) && (take_w || poll_due); // [R17]
		newdata_w = (kind_q == PSC_OP_READ) && (stat_bit_q == STAT_NEW); // [R11]
		again_w   = 1'h0;
		nkind_w   = kind_q;
		npend_w   = pend_q;
		done_w    = 1'h0;
		case (kind_q)
			PSC_OP_READ: begin
				if (rpt_q && stat_bit_q == STAT_OLD) begin
					again_w = 1'h1; // [R12]
				end else if (pend_q) begin
					again_w = 1'h1; // [R17]
					nkind_w = pend_op_q;
					npend_w = 1'h0;
				end else begin
					done_w = rpt_q;
				end
			end
			PSC_OP_WRITE: begin
				if (stat_bit_q == STAT_REJECT)
					again_w = 1'h1; // [R16]
				else
					done_w = 1'h1; // [R15]
			end
			default: done_w = 1'h1;
		endcase
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_RST;
		end else begin
			case (st_q)
				ST_RST:  if (ph_last) st_q <= ST_IDLE;
				ST_IDLE: if (start_w) st_q <= ST_LOW;
				ST_LOW:  if (ph_last) st_q <= ST_HIGH;
				ST_HIGH: begin
					if (ph_last) begin
						if (!frame_end)
							st_q <= ST_LOW;
						else if (psc_is_data(kind_q))
							st_q <= ST_GAP; // [R10]
						else
							st_q <= ST_IDLE;
					end
				end
				ST_GAP:  if (ph_last) st_q <= again_q ? ST_LOW : ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ph_q <= PH_ZERO;
		else if (ph_last || st_q == ST_IDLE)
			ph_q <= PH_ZERO;
		else
			ph_q <= ph_q + 8'h01;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			bit_q <= BIT_START;
		else if (st_q == ST_HIGH && ph_last)
			bit_q <= frame_end ? BIT_START : bit_q + 4'h1;
		else if (st_q != ST_LOW && st_q != ST_HIGH)
			bit_q <= BIT_START;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			poll_q <= 24'h000000;
		else if (st_q != ST_IDLE || poll_due)
			poll_q <= 24'h000000;
		else
			poll_q <= poll_q + 24'h000001;
	end

	// ------------------------------------------------------------
	// operation bookkeeping
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			kind_q    <= PSC_OP_READ;
			pend_op_q <= PSC_OP_READ;
			pend_q    <= 1'h0;
			rpt_q     <= 1'h0;
			again_q   <= 1'h0;
			wdata_q   <= 8'h00;
		end else if (take_w) begin
			wdata_q   <= cmd_wdata;
			kind_q    <= PSC_OP_READ; // [R17]
			pend_op_q <= psc_op_t'(cmd_op);
			rpt_q     <= (psc_op_t'(cmd_op) == PSC_OP_READ);
			pend_q    <= (psc_op_t'(cmd_op) != PSC_OP_READ);
		end else if (start_w) begin
			kind_q <= PSC_OP_READ;
			rpt_q  <= 1'h0;
			pend_q <= 1'h0;
		end else if (frame_end) begin
			again_q <= again_w;
			kind_q  <= nkind_w;
			pend_q  <= npend_w;
			if (nkind_w != PSC_OP_READ)
				rpt_q <= 1'h0;
		end
	end

	// ------------------------------------------------------------
	// shifter and trailing status capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sh_q       <= 8'h00;
			stat_bit_q <= 1'h0;
		end else if (st_q == ST_LOW && ph_q == PH_ZERO && bit_q == BIT_START) begin
			sh_q <= (kind_q == PSC_OP_WRITE) ? wdata_q : 8'h00; // [R16]
		end else if (st_q == ST_HIGH && ph_last) begin
			if (bit_q >= BIT_DFIRST && bit_q <= BIT_DLAST)
				sh_q <= {sh_q[6:0], sdo_s_q}; // [R7]
			if (bit_q == BIT_STAT)
				stat_bit_q <= sdo_s_q; // [R13] [R14]
		end
	end

	// ------------------------------------------------------------
	// serial pins
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spi_sclk <= 1'h0;
			spi_cs   <= 1'h0;
			spi_sdi  <= 1'h0;
		end else begin
			if (st_q == ST_LOW && ph_last)
				spi_sclk <= 1'h1; // [R2] [R3]
			else if (st_q == ST_HIGH && ph_last)
				spi_sclk <= 1'h0;
			if (frame_end)
				spi_cs <= 1'h0;
			else if (st_q == ST_LOW && ph_q == PH_ZERO && bit_q == BIT_START)
				spi_cs <= 1'h1; // [R9]
			if (frame_end) begin
				spi_sdi <= 1'h0;
			end else if (st_q == ST_LOW && ph_q == PH_ZERO) begin
				// launched at the start of the low phase so the device sees it settled at the rise
				if (bit_q == BIT_START)
					spi_sdi <= 1'h1; // [R5] [R8]
				else if (bit_q == BIT_DIR)
					spi_sdi <= kind_q[1]; // [R6]
				else if (bit_q == BIT_TGT)
					spi_sdi <= kind_q[0]; // [R6]
				else if (bit_q <= BIT_DLAST)
					spi_sdi <= sh_q[7]; // [R7]
				else
					spi_sdi <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// user side and device reset / straps
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_ready  <= 1'h0;
			rsp_valid  <= 1'h0;
			rsp_data   <= 8'h00;
			rx_valid   <= 1'h0;
			rx_data    <= 8'h00;
			rx_full_n  <= 1'h1;
			tx_empty_n <= 1'h1;
		end else begin
			cmd_ready <= (st_q == ST_IDLE) && !start_w;
			rsp_valid <= frame_end && done_w;
			rx_valid  <= frame_end && newdata_w; // [R11] [R12]
			if (frame_end && done_w)
				rsp_data <= sh_q;
			if (frame_end && newdata_w)
				rx_data <= sh_q;
			if (frame_end && kind_q == PSC_OP_STATUS) begin
				rx_full_n  <= sh_q[RX_FULL_N_BIT]; // [R19]
				tx_empty_n <= sh_q[TX_EMPTY_N_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dev_reset_n      <= 1'h0;
			iface_strap_high <= 1'h1;
			iface_strap_low  <= 1'h0;
			strap_oe_n       <= 1'h0;
		end else begin
			dev_reset_n      <= (st_q != ST_RST);
			iface_strap_high <= 1'h1; // [R1]
			iface_strap_low  <= 1'h0; // [R1]
			// straps held past the device reset release until traffic begins
			if (st_q == ST_LOW)
				strap_oe_n <= 1'h1;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_strap_in_reset: assert property (!dev_reset_n |-> !strap_oe_n && iface_strap_high && !iface_strap_low) // [R1]
		else $error("straps not driven during device reset");
	a_clock_gated_cs: assert property (!spi_cs |-> !spi_sclk) // [R2]
		else $error("serial clock runs without select");
	a_sclk_high_len: assert property ($rose(spi_sclk) |-> spi_sclk[*5] ##1 !spi_sclk) // [R3]
		else $error("serial clock high phase wrong");
	a_frame_length: assert property ($rose(spi_cs) |-> ##128 spi_cs ##1 !spi_cs) // [R4] [R9]
		else $error("select not held for thirteen cycles");
	a_start_cond: assert property ($rose(spi_cs) |-> spi_sdi ##4 $rose(spi_sclk)) // [R5] [R8]
		else $error("start condition not presented");
	a_write_msb: assert property (st_q == ST_LOW && ph_q == PH_ZERO && bit_q == BIT_DFIRST &&
		kind_q == PSC_OP_WRITE |=> spi_sdi == wdata_q[7]) // [R7]
		else $error("write data not msb first");
	a_data_gap: assert property ($fell(spi_cs) && psc_is_data(kind_q) |-> !spi_cs[*8]) // [R10]
		else $error("select gap after data op too short");
	a_write_retry: assert property (frame_end && kind_q == PSC_OP_WRITE && stat_bit_q &&
		!pend_q |=> ##[1:20] $rose(spi_cs) && kind_q == PSC_OP_WRITE) // [R16]
		else $error("rejected write not retried");
	a_poll_first: assert property (take_w && psc_op_t'(cmd_op) == PSC_OP_WRITE
		|=> kind_q == PSC_OP_READ && pend_q) // [R17]
		else $error("no poll read before command");
	a_read_repeat: assert property (frame_end && kind_q == PSC_OP_READ && rpt_q && stat_bit_q
		|-> !rx_valid ##1 !rx_valid ##[1:20] $rose(spi_cs)) // [R12]
		else $error("old read data not discarded and repeated");

	c_status_done: cover property (frame_end && kind_q == PSC_OP_STATUS);
	c_write_reject: cover property (frame_end && kind_q == PSC_OP_WRITE && stat_bit_q);
	c_read_new: cover property (rx_valid);
	c_write_accept: cover property (frame_end && kind_q == PSC_OP_WRITE && !stat_bit_q);
endmodule // psc_host

// ---- tb/psc_dev_model.sv ----
// behavioural model of the device side of the polled spi command port
`timescale 1ns/10ps
module psc_dev_model
	import psc_pkg::*;
#(
	parameter int         RX_DEPTH = 2,
	parameter logic [1:0] IRQ_EN   = 2'h1,
	parameter real        T_MIN    = 83.0
) (
	input  wire logic spi_sclk,
	input  wire logic spi_cs,
	input  wire logic spi_sdi,
	output logic      spi_sdo,
	input  wire logic dev_reset_n,
	input  wire logic strap_hi,
	input  wire logic strap_lo
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic [7:0] sh_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic [1:0] op_q = 2'h0;
	logic       busy_q = 1'b0, mode_spi = 1'b0, data_op = 1'b0, have_new = 1'b0;
	int         bitn = 0, err = 0, old_reads = 0, rejects = 0;
	realtime    t_rise = -1.0e3, t_fall = -1.0e3;
	initial spi_sdo = 1'b0;
	always @(posedge dev_reset_n) mode_spi = strap_hi === 1'b1 && strap_lo === 1'b0;
	always @(negedge spi_cs) t_fall = $realtime;
	// ------------------------------------------------------------
	// frame engine, everything on the rising serial clock
	// ------------------------------------------------------------
	always @(posedge spi_sclk) begin
		if ($realtime - t_rise < T_MIN) err++;
		t_rise = $realtime;
		if (!mode_spi) begin
			spi_sdo = ~spi_sdo;
		end else if (!busy_q) begin
			spi_sdo = ~spi_sdo;
			if (spi_cs && spi_sdi) begin
				if (data_op && $realtime - t_fall < T_MIN) err++;
				busy_q = 1'b1;
				bitn = 0;
			end
		end else if (!spi_cs) begin
			busy_q = 1'b0;
			err++;
			spi_sdo = ~spi_sdo;
		end else begin
			bitn++;
			if (bitn <= 2) op_q = {op_q[0], spi_sdi};
			if (bitn == 3 && op_q[1]) begin
				have_new = txq.size() != 0;
				sh_q = op_q[0] ? {2'h0, IRQ_EN, 2'h0, have_new, rxq.size() < RX_DEPTH}
					: (have_new ? txq[0] : last_q);
			end
			if (bitn >= 3 && bitn <= 10) begin
				if (op_q[1]) spi_sdo = sh_q[10 - bitn];
				else sh_q = {sh_q[6:0], spi_sdi};
			end
			if (bitn == 11) begin
				if (op_q == 2'h3) spi_sdo = 1'b0;
				else if (op_q == 2'h2 && have_new) begin
					last_q = txq.pop_front();
					spi_sdo = STAT_NEW;
				end else if (op_q == 2'h2) begin
					old_reads++;
					spi_sdo = STAT_OLD;
				end else if (rxq.size() < RX_DEPTH) begin
					rxq.push_back(sh_q);
					spi_sdo = STAT_ACCEPT;
				end else begin
					rejects++;
					spi_sdo = STAT_REJECT;
				end
			end
			if (bitn == 12) begin
				spi_sdo = ~spi_sdo;
				busy_q = 1'b0;
				data_op = op_q != 2'h3;
			end
		end
	end
endmodule // psc_dev_model

// ---- tb/test_psc_host.sv ----
// self-checking bench for the polled spi command-port host controller
`timescale 1ns/10ps
module test_psc_host;
	import psc_pkg::*;
	logic       clk, resetn, cmd_valid, cmd_ready, rsp_valid, rx_valid, rx_full_n;
	logic       tx_empty_n, dev_reset_n, iface_strap_high, iface_strap_low, strap_oe_n;
	logic       spi_sclk, spi_cs, spi_sdi, spi_sdo;
	logic [1:0] cmd_op;
	logic [7:0] cmd_wdata, rsp_data, rx_data, rd;
	logic [7:0] got_q[$];
	int         failures = 0, total_checks = 0, n0, bad;
	// released straps settle to their resistors
	wire strap_hi_w = strap_oe_n | iface_strap_high;
	wire strap_lo_w = !strap_oe_n & iface_strap_low;
	psc_host #(.POLL_CYC(3000)) DUT (
		.clk, .resetn, .cmd_valid, .cmd_op, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data,
		.rx_valid, .rx_data, .rx_full_n, .tx_empty_n, .dev_reset_n, .iface_strap_high,
		.iface_strap_low, .strap_oe_n, .spi_sclk, .spi_cs, .spi_sdi, .spi_sdo
	);
	psc_dev_model MDL (
		.spi_sclk, .spi_cs, .spi_sdi, .spi_sdo, .dev_reset_n,
		.strap_hi(strap_hi_w), .strap_lo(strap_lo_w)
	);
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (rx_valid === 1'b1) got_q.push_back(rx_data);
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic do_cmd(input logic [1:0] op, input logic [7:0] wd);
		int   n;
		logic rdy;
		n = 0;
		rdy = 1'b0;
		cmd_op = op;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		while (!rdy && n < 2000) begin
			rdy = cmd_ready;
			@(posedge clk);
			#1;
			n++;
		end
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 6000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(8'(n < 6000), 8'h01, "command completes");
		rd = rsp_data;
		// one more edge so the stream collector has taken the pulse
		@(posedge clk);
		#1;
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop;
	end
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_wdata = 8'h00;
		repeat (10) @(posedge clk);
		#1;
		check({3'h0, iface_strap_high, iface_strap_low, strap_oe_n, dev_reset_n, spi_cs},
			8'h10, "reset pins");
		resetn = 1'b1;
		do_cmd(2'h3, 8'h00);
		check(rd, 8'h11, "status empty");
		check({6'h0, rx_full_n, tx_empty_n}, 8'h02, "flags empty");
		check({7'h0, MDL.mode_spi}, 8'h01, "strap mode");
		$display("test status read done");
		MDL.txq.push_back(8'hA5);
		do_cmd(2'h2, 8'h00);
		check(rd, 8'hA5, "read byte");
		check(got_q[$], 8'hA5, "read stream");
		check(8'(MDL.txq.size()), 8'h00, "tx drained");
		n0 = MDL.old_reads;
		fork
			begin
				repeat (600) @(posedge clk);
				#3;
				MDL.txq.push_back(8'h3C);
			end
		join_none
		do_cmd(2'h2, 8'h00);
		check(rd, 8'h3C, "read after old");
		check(8'(MDL.old_reads > n0), 8'h01, "old reads seen");
		$display("test data read done");
		MDL.txq.push_back(8'h77);
		do_cmd(2'h0, 8'h96);
		check(got_q[$], 8'h77, "poll before write");
		check(MDL.rxq[0], 8'h96, "written byte");
		do_cmd(2'h0, 8'h5A);
		MDL.txq.push_back(8'h11);
		MDL.txq.push_back(8'h22);
		do_cmd(2'h3, 8'h00);
		check(rd, 8'h12, "status full");
		check({6'h0, rx_full_n, tx_empty_n}, 8'h01, "flags full");
		n0 = MDL.rejects;
		fork
			begin
				repeat (800) @(posedge clk);
				#3;
				void'(MDL.rxq.pop_front());
			end
		join_none
		do_cmd(2'h0, 8'hC3);
		check(8'(MDL.rejects > n0), 8'h01, "full rejects");
		check(8'(MDL.rxq.size()), 8'h02, "rx count");
		check(MDL.rxq[1], 8'hC3, "retried byte");
		$display("test data write done");
		repeat (15) @(posedge clk);
		#1;
		cmd_op = 2'h1;
		cmd_valid = 1'b1;
		bad = 0;
		repeat (40) begin
			@(posedge clk);
			#1;
			if (cmd_ready !== 1'b1 || spi_cs !== 1'b0 || rsp_valid !== 1'b0) bad++;
		end
		cmd_valid = 1'b0;
		check(8'(bad), 8'h00, "unused op refused");
		check(8'(MDL.err), 8'h00, "link timing");
		check({7'h0, strap_oe_n}, 8'h01, "straps released");
		$display("test unused op done");
		resetn = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({3'h0, iface_strap_high, iface_strap_low, strap_oe_n, dev_reset_n, spi_cs},
			8'h10, "pins in second reset");
		check({6'h0, rx_full_n, tx_empty_n}, 8'h03, "flags in reset");
		resetn = 1'b1;
		do_cmd(2'h3, 8'h00);
		check(rd, 8'h10, "status after reset");
		check({7'h0, MDL.mode_spi}, 8'h01, "strap mode again");
		$display("test mid-run reset done");
		report_and_stop;
	end
endmodule // test_psc_host
